// *** rtl/alarm_compare.sv ***
// Alarm comparators of counters one and two with 32-bit chaining.
// Assumes counter values and normal outputs come from core clock logic.
`timescale 1ns/1ps
`default_nettype none
module alarm_compare
	import timer_mm_pkg::*;
(
	input  wire logic        core_clk_i,
	input  wire logic        sys_rst_i,
	mm_cfg_if.cmp            cfg,
	input  wire logic [15:0] counter1_value_i,
	input  wire logic [15:0] counter2_value_i,
	input  wire logic [15:0] alarm1_i,
	input  wire logic [15:0] alarm2_i,
	input  wire logic [2:0]  out_ctl1_i,
	input  wire logic [2:0]  out_ctl2_i,
	input  wire logic        counter1_tc_out_i,
	input  wire logic        counter2_tc_out_i,
	output logic             counter1_output_o,
	output logic             counter2_output_o
);
	typedef struct packed {
		logic counter1_output;
		logic counter2_output;
	} cmp_state_t;

	cmp_state_t q;
	cmp_state_t d;
	logic       eq1;
	logic       eq2;
	logic       chained;
	logic       match2;

	always_comb begin
		d = q;
		eq1 = counter1_value_i == alarm1_i; // [R24] [R5]
		eq2 = counter2_value_i == alarm2_i; // [R24] [R5]
		chained = !cfg.tod_enable && cfg.cmp1_enable && cfg.cmp2_enable;
		match2 = chained ? (eq1 && eq2) : eq2; // [R6]
		d.counter1_output = cfg.cmp1_enable ? apply_pol(eq1, out_ctl1_i) // [R3] [R4]
			: counter1_tc_out_i;
		d.counter2_output = cfg.cmp2_enable ? apply_pol(match2, out_ctl2_i) // [R3] [R4]
			: counter2_tc_out_i;
	end

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign counter1_output_o = q.counter1_output;
	assign counter2_output_o = q.counter2_output;

	chk_cmp_chain_32: assert property (@(posedge core_clk_i) // [R6]
		disable iff (sys_rst_i)
		chained && !eq1 && out_ctl2_i != OC_LOW |=> !counter2_output_o)
		else $error("chained compare true without full match");
	chk_cmp_low_pol: assert property (@(posedge core_clk_i) // [R4]
		disable iff (sys_rst_i)
		cfg.cmp1_enable && out_ctl1_i == OC_LOW && eq1 |=> !counter1_output_o)
		else $error("active-low compare output not low on match");
	chk_cmp_hold_true: assert property (@(posedge core_clk_i) // [R5]
		disable iff (sys_rst_i)
		cfg.cmp1_enable && out_ctl1_i != OC_LOW && eq1 ##1 $stable(
		counter1_value_i) && $stable(alarm1_i) && cfg.cmp1_enable
		&& out_ctl1_i != OC_LOW |=> counter1_output_o)
		else $error("compare output dropped while equal");
	chk_cmp_bypass_out: assert property (@(posedge core_clk_i) // [R3]
		disable iff (sys_rst_i)
		!cfg.cmp1_enable |=> counter1_output_o == $past(counter1_tc_out_i))
		else $error("normal output not passed when compare off");
endmodule
`default_nettype wire

// *** rtl/freq_out_gen.sv ***
// Frequency output: source pick, divide by 1..16, software gate.
// Assumes source levels are already in the core clock domain.
`timescale 1ns/1ps
`default_nettype none
module freq_out_gen
	import timer_mm_pkg::*;
(
	input  wire logic        core_clk_i,
	input  wire logic        sys_rst_i,
	mm_cfg_if.freq           cfg,
	input  wire logic [14:0] src_level_i,
	output logic             freq_output_o
);
	typedef struct packed {
		logic       sel;
		logic [3:0] cnt;
		logic       freq_output;
	} freq_output_state_t;

	freq_output_state_t q;
	freq_output_state_t d;
	logic        sel;
	logic        rise;
	logic [4:0]  n_div;

	always_comb begin
		d = q;
		if (cfg.fsrc_sel == 4'h0) begin
			sel = src_level_i[FSRC_F1_IDX]; // [R8]
		end else begin
			sel = src_level_i[cfg.fsrc_sel - 4'h1]; // [R7]
		end
		n_div = (cfg.fdiv == 4'h0) ? FDIV_ZERO_N : {1'b0, cfg.fdiv}; // [R10]
		rise = sel && !q.sel;
		d.sel = sel;
		if (rise) begin
			if ({1'b0, q.cnt} + 5'h01 >= n_div) begin // [R9]
				d.cnt = 4'h0;
			end else begin
				d.cnt = q.cnt + 4'h1;
			end
		end
		if (cfg.gate_off) begin
			d.freq_output = 1'b0; // [R11]
		end else if (n_div == 5'h01) begin
			d.freq_output = q.sel;
		end else begin
			d.freq_output = {1'b0, q.cnt} < (n_div >> 1);
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign freq_output_o = q.freq_output;

	chk_freq_output_gated_low: assert property (@(posedge core_clk_i) // [R11]
		disable iff (sys_rst_i) cfg.gate_off |=> !freq_output_o)
		else $error("freq output not low while gated off");
	chk_fdiv_wrap_zero: assert property (@(posedge core_clk_i) // [R9]
		disable iff (sys_rst_i)
		rise && ({1'b0, q.cnt} + 5'h01 >= n_div) |=> q.cnt == 4'h0)
		else $error("divider did not wrap at its ratio");
	chk_fsrc_default_f1: assert property (@(posedge core_clk_i) // [R8]
		disable iff (sys_rst_i)
		cfg.fsrc_sel == 4'h0 |=> q.sel == $past(src_level_i[FSRC_F1_IDX]))
		else $error("source code zero does not pick first frequency");
endmodule
`default_nettype wire

// *** rtl/mm_cfg_if.sv ***
// Mode fields shared by the control core and its two helpers.
// Assumes all parties run on the core clock.
`timescale 1ns/1ps
`default_nettype none
interface mm_cfg_if;
	logic [3:0] fsrc_sel;
	logic [3:0] fdiv;
	logic       gate_off;
	logic       tod_enable;
	logic       cmp1_enable;
	logic       cmp2_enable;
	modport owner (output fsrc_sel, fdiv, gate_off, tod_enable,
		cmp1_enable, cmp2_enable);
	modport freq (input fsrc_sel, fdiv, gate_off);
	modport cmp (input tod_enable, cmp1_enable, cmp2_enable);
endinterface
`default_nettype wire

// *** rtl/timer_master_mode_control.sv ***
// Global mode control of a five-counter timing controller: host port,
// mode word, frequency scaler, gating, comparators and frequency output.
// Assumes host pins are asynchronous; counter values share core_clk_i.
//
// Summary of operation
// R1: Both time-of-day bits zero: counters one and two act like others.
// R2: Either time-of-day bit set enables 24-hour decade decoding.
// R3: Enable bits route each comparator result onto its counter output.
// R4: Compare polarity high for codes 001 or 010, low for 101.
// R5: Compare output stays true until the count changes away.
// R6: Without time-of-day, both enabled: output two needs 32-bit match.
// R7: Four-bit source field picks source, gate or internal frequency.
// R8: Source code zero guarantees an active frequency after reset.
// R9: Divider field divides the chosen source by 1 to 16.
// R10: Divider resets to divide by sixteen.
// R11: Gate bit set forces the frequency output low; reset gates on.
// R12: Gate bit written with the word or set and cleared by command.
// R13: Wide bus moves whole words; byte pointer stays set.
// R14: Narrow bus moves bytes on low lines; pointer toggles per byte.
// R15: Narrow bus: data lines eight to twelve AND into counter gates.
// R16: Sequencing bit one stops automatic data pointer stepping.
// R17: Sequencing bit written with the word or by set/clear command.
// R18: Scaler bit picks binary steps of 16 or decimal steps of 10.
// R19: Modes A-F reload from load register; A-C once, D-F repeat.
// R20: Gate code 000 ungated; level counts while active; edge starts.
// R21: Modes G-I count to terminal count twice then disarm.
// R22: Modes J-L count to terminal count repeatedly.
// R23: Power-on or master reset command clears the whole mode word.
// R24: Enabled comparator matches when counter equals its alarm.
`timescale 1ns/1ps
`default_nettype none
module timer_master_mode_control
	import timer_mm_pkg::*;
(
	input  wire logic        core_clk_i,
	input  wire logic        sys_rst_i,
	input  wire logic        chip_sel_n_i,
	input  wire logic        rd_n_i,
	input  wire logic        wr_n_i,
	input  wire logic        ctl_sel_i,
	input  wire logic [15:0] db_i,
	output logic      [15:0] db_o,
	output logic             db_oe_o,
	input  wire logic [4:0]  source_pin_i,
	input  wire logic [4:0]  gate_pin_i,
	input  wire logic [15:0] counter1_value_i,
	input  wire logic [15:0] counter2_value_i,
	input  wire logic [15:0] alarm1_i,
	input  wire logic [15:0] alarm2_i,
	input  wire logic [2:0]  out_ctl1_i,
	input  wire logic [2:0]  out_ctl2_i,
	input  wire logic        counter1_tc_out_i,
	input  wire logic        counter2_tc_out_i,
	input  wire logic [15:0] counter_mode_i,
	output logic             counter1_output_o,
	output logic             counter2_output_o,
	output logic             freq_output_o,
	output logic             time_of_day_o,
	output logic      [4:0]  gate_eff_o,
	output logic             byte_ptr_o,
	output logic             wide_bus_select_o,
	output logic             pointer_autoseq_disable_o,
	output logic             scaler_bcd_select_o,
	output logic      [4:0]  internal_freq_o,
	output logic             mode_valid_o,
	output logic             mode_reload_load_o,
	output logic      [1:0]  mode_tc_count_o,
	output logic      [1:0]  mode_gate_kind_o
);
	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [3:0]       bus_s1;
		logic [3:0]       bus_s2;
		logic [15:0]      db_s1;
		logic [15:0]      db_s2;
		logic [4:0]       src_s1;
		logic [4:0]       src_s2;
		logic [4:0]       gate_s1;
		logic [4:0]       gate_s2;
		logic             rd_prev;
		logic             wr_prev;
		logic [15:0]      mm;
		logic             hi_next;
		logic [7:0]       lo_byte;
		logic [15:0]      dout;
		logic             oe;
		logic [4:0]       gate_eff;
		logic             time_of_day;
		logic             f1;
		logic [3:0][3:0]  digit;
		mode_attr_t       mode;
	} core_state_t;

	core_state_t q;
	core_state_t d;
	logic        cs_s;
	logic        rd_s;
	logic        wr_s;
	logic        ctl_s;
	logic [15:0] db_s;
	logic        wr_done;
	logic        rd_done;
	logic        wide;
	logic        carry;
	logic [3:0]  scl_max;
	logic [4:0]  int_freq;
	logic [14:0] src_level;

	mm_cfg_if cfg ();

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		d = q;
		// Pins held active high so a cleared stage reads as idle
		d.bus_s1 = {!chip_sel_n_i, !rd_n_i, !wr_n_i, ctl_sel_i};
		d.bus_s2 = q.bus_s1;
		d.db_s1 = db_i;
		d.db_s2 = q.db_s1;
		d.src_s1 = source_pin_i;
		d.src_s2 = q.src_s1;
		d.gate_s1 = gate_pin_i;
		d.gate_s2 = q.gate_s1;
		cs_s = q.bus_s2[3];
		rd_s = q.bus_s2[2];
		wr_s = q.bus_s2[1];
		ctl_s = q.bus_s2[0];
		db_s = q.db_s2;
		d.rd_prev = rd_s;
		d.wr_prev = wr_s;
		wr_done = cs_s && q.wr_prev && !wr_s;
		rd_done = cs_s && q.rd_prev && !rd_s;
		wide = q.mm[WIDE_POS];

		// Host writes and reads
		if (wr_done && ctl_s) begin
			unique case (db_s[7:0])
				CMD_FGATE_SET: d.mm[FGATE_POS] = 1'b1; // [R12]
				CMD_FGATE_CLR: d.mm[FGATE_POS] = 1'b0; // [R12]
				CMD_WIDE_SET: d.mm[WIDE_POS] = 1'b1;
				CMD_WIDE_CLR: d.mm[WIDE_POS] = 1'b0;
				CMD_SEQ_SET: d.mm[SEQ_POS] = 1'b1; // [R17]
				CMD_SEQ_CLR: d.mm[SEQ_POS] = 1'b0; // [R17]
				CMD_MASTER_RESET: begin
					d.mm = MM_RESET; // [R23]
					d.hi_next = 1'b0;
				end
				default: d.mm = q.mm;
			endcase
		end else if (wr_done) begin
			if (wide) begin
				d.mm = db_s; // [R13] [R12] [R17]
			end else if (!q.hi_next) begin
				d.lo_byte = db_s[7:0]; // [R14]
				d.hi_next = 1'b1;
			end else begin
				d.mm = {db_s[7:0], q.lo_byte}; // [R14]
				d.hi_next = 1'b0;
			end
		end else if (rd_done && !ctl_s && !wide) begin
			d.hi_next = !q.hi_next; // [R14]
		end
		if (d.mm[WIDE_POS]) begin
			d.hi_next = 1'b0; // [R13]
		end
		d.oe = cs_s && rd_s;
		if (ctl_s) begin
			d.dout = {13'h0000, counter2_output_o, counter1_output_o,
				!q.hi_next};
		end else if (wide) begin
			d.dout = q.mm; // [R13]
		end else begin
			d.dout = {8'h00, q.hi_next ? q.mm[15:8] : q.mm[7:0]}; // [R14]
		end

		// Auxiliary gates on the upper data lines in narrow mode
		for (int i = 0; i < 5; i++) begin
			d.gate_eff[i] = q.gate_s2[i] && (wide || q.db_s2[8 + i]); // [R15]
		end
		d.time_of_day = q.mm[TOD_LO_POS] || q.mm[TOD_HI_POS]; // [R1] [R2]

		// Frequency scaler chain
		scl_max = q.mm[BCD_POS] ? SCALE_BCD_MAX : SCALE_BIN_MAX; // [R18]
		d.f1 = !q.f1;
		carry = !q.f1;
		for (int k = 0; k < 4; k++) begin
			if (carry) begin
				d.digit[k] = (q.digit[k] >= scl_max) ? 4'h0 // [R18]
					: q.digit[k] + 4'h1;
			end
			carry = carry && (q.digit[k] >= scl_max);
		end
		int_freq[0] = q.f1;
		for (int k = 0; k < 4; k++) begin
			int_freq[k + 1] = digit_half(q.digit[k], q.mm[BCD_POS]);
		end
		src_level = {int_freq, q.gate_eff, q.src_s2};

		d.mode = decode_mode(counter_mode_i); // [R19] [R20] [R21] [R22]
	end

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			q <= '0; // [R23] [R10]
		end else begin
			q <= d;
		end
	end

	// ------------------------------------------------------------------
	// Helpers and outputs
	// ------------------------------------------------------------------
	assign cfg.fsrc_sel = q.mm[FSRC_MSB:FSRC_LSB]; // [R7]
	assign cfg.fdiv = q.mm[FDIV_MSB:FDIV_LSB]; // [R9]
	assign cfg.gate_off = q.mm[FGATE_POS]; // [R11]
	assign cfg.tod_enable = q.time_of_day; // [R6]
	assign cfg.cmp1_enable = q.mm[CMP1_EN_POS]; // [R3]
	assign cfg.cmp2_enable = q.mm[CMP2_EN_POS]; // [R3]

	freq_out_gen u_freq (
		.core_clk_i    (core_clk_i),
		.sys_rst_i     (sys_rst_i),
		.cfg           (cfg.freq),
		.src_level_i   (src_level),
		.freq_output_o (freq_output_o)
	);

	alarm_compare u_cmp (
		.core_clk_i        (core_clk_i),
		.sys_rst_i         (sys_rst_i),
		.cfg               (cfg.cmp),
		.counter1_value_i  (counter1_value_i),
		.counter2_value_i  (counter2_value_i),
		.alarm1_i          (alarm1_i),
		.alarm2_i          (alarm2_i),
		.out_ctl1_i        (out_ctl1_i),
		.out_ctl2_i        (out_ctl2_i),
		.counter1_tc_out_i (counter1_tc_out_i),
		.counter2_tc_out_i (counter2_tc_out_i),
		.counter1_output_o (counter1_output_o),
		.counter2_output_o (counter2_output_o)
	);

	assign db_o = q.dout;
	assign db_oe_o = q.oe;
	assign time_of_day_o = q.time_of_day;
	assign gate_eff_o = q.gate_eff;
	assign byte_ptr_o = !q.hi_next;
	assign wide_bus_select_o = q.mm[WIDE_POS];
	assign pointer_autoseq_disable_o = q.mm[SEQ_POS]; // [R16]
	assign scaler_bcd_select_o = q.mm[BCD_POS];
	assign internal_freq_o = {q.digit[3][3], q.digit[2][3], q.digit[1][3],
		q.digit[0][3], q.f1};
	assign mode_valid_o = q.mode.valid;
	assign mode_reload_load_o = q.mode.reload_load;
	assign mode_tc_count_o = q.mode.tc_count;
	assign mode_gate_kind_o = q.mode.gate_kind;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking dc @(posedge core_clk_i); endclocking
	default disable iff (sys_rst_i);

	sequence cmd_seen(logic [7:0] c);
		wr_done && ctl_s && db_s[7:0] == c;
	endsequence
	sequence byte_write;
		wr_done && !ctl_s && !wide;
	endsequence

	chk_master_reset_clr: assert property ( // [R23]
		cmd_seen(CMD_MASTER_RESET) |=> q.mm == MM_RESET && byte_ptr_o)
		else $error("master reset did not clear mode word");
	chk_fgate_set_only: assert property ( // [R12]
		cmd_seen(CMD_FGATE_SET) |=> q.mm[FGATE_POS]
		&& q.mm[11:0] == $past(q.mm[11:0]))
		else $error("gate set command disturbed other bits");
	chk_seq_clr_cmd: assert property ( // [R17] [R16]
		cmd_seen(CMD_SEQ_CLR) |=> !pointer_autoseq_disable_o)
		else $error("sequencing clear command ignored");
	chk_byte_pair_word: assert property ( // [R14]
		byte_write ##1 (!wr_done)[*8] ##1 (!wr_done)[*4] ##1 byte_write
		|=> q.mm == {$past(db_s[7:0]), $past(db_s[7:0], 14)}
		|| byte_ptr_o == 1'b0)
		else $error("byte pair did not assemble the word");
	chk_byte_toggle_ptr: assert property ( // [R14]
		byte_write |=> byte_ptr_o != $past(byte_ptr_o))
		else $error("byte pointer did not toggle");
	chk_wide_ptr_set: assert property ( // [R13]
		wide_bus_select_o |-> byte_ptr_o)
		else $error("byte pointer clear in wide mode");
	chk_aux_gate_and: assert property ( // [R15]
		!wide && !db_s[8] |=> !gate_eff_o[0])
		else $error("auxiliary gate did not block counter one");
	chk_tod_disabled: assert property ( // [R1]
		q.mm[TOD_HI_POS:TOD_LO_POS] == 2'b00 |=> !time_of_day_o)
		else $error("time-of-day on with both bits clear");
	chk_tod_enabled: assert property ( // [R2]
		q.mm[TOD_LO_POS] || q.mm[TOD_HI_POS] |=> time_of_day_o)
		else $error("time-of-day off with a bit set");
	chk_scaler_bcd_range: assert property ( // [R18]
		q.mm[BCD_POS] && q.digit[0] <= SCALE_BCD_MAX ##1 q.mm[BCD_POS]
		|-> q.digit[0] <= SCALE_BCD_MAX)
		else $error("decimal scaler digit left range");
	chk_mode_once_load: assert property ( // [R19]
		counter_mode_i[CM_SPECIAL:CM_REPEAT] == 3'b000 |=>
		mode_tc_count_o == 2'd1 && mode_reload_load_o)
		else $error("modes A to C not count-once from load");
	chk_gate_code_none: assert property ( // [R20]
		counter_mode_i[15:13] == GC_NONE |=> mode_gate_kind_o == GATE_NONE)
		else $error("gate code zero not ungated");
	chk_mode_twice_tc: assert property ( // [R21]
		counter_mode_i[CM_SPECIAL:CM_REPEAT] == 3'b010 |=>
		mode_tc_count_o == 2'd2)
		else $error("modes G to I not count-twice");
	chk_mode_repeat_tc: assert property ( // [R22]
		!counter_mode_i[CM_SPECIAL] && counter_mode_i[CM_REPEAT] |=>
		mode_tc_count_o == 2'd0)
		else $error("repeating modes disarm");
endmodule
`default_nettype wire

// *** rtl/timer_mm_pkg.sv ***
// Constants, field layout and helpers of the global mode control block.
// Assumes one core clock; used by the design modules of the block.
package timer_mm_pkg;

	// --------------------------------------------------------------
	// Global mode control word
	// --------------------------------------------------------------
	localparam logic [15:0] MM_RESET      = 16'h0000;
	localparam int          TOD_LO_POS    = 0;
	localparam int          TOD_HI_POS    = 1;
	localparam int          CMP1_EN_POS   = 2;
	localparam int          CMP2_EN_POS   = 3;
	localparam int          FSRC_LSB      = 4;
	localparam int          FSRC_MSB      = 7;
	localparam int          FDIV_LSB      = 8;
	localparam int          FDIV_MSB      = 11;
	localparam int          FGATE_POS     = 12;
	localparam int          WIDE_POS      = 13;
	localparam int          SEQ_POS       = 14;
	localparam int          BCD_POS       = 15;

	// --------------------------------------------------------------
	// Commands on the control port
	// --------------------------------------------------------------
	localparam logic [7:0] CMD_FGATE_SET    = 8'h01;
	localparam logic [7:0] CMD_FGATE_CLR    = 8'h02;
	localparam logic [7:0] CMD_WIDE_SET     = 8'h03;
	localparam logic [7:0] CMD_WIDE_CLR     = 8'h04;
	localparam logic [7:0] CMD_SEQ_SET      = 8'h05;
	localparam logic [7:0] CMD_SEQ_CLR      = 8'h06;
	localparam logic [7:0] CMD_MASTER_RESET = 8'hff;

	// --------------------------------------------------------------
	// Sources, scaler, output control and counter mode fields
	// --------------------------------------------------------------
	localparam int          FSRC_F1_IDX   = 10;
	localparam logic [4:0]  FDIV_ZERO_N   = 5'h10;
	localparam logic [3:0]  SCALE_BIN_MAX = 4'hf;
	localparam logic [3:0]  SCALE_BCD_MAX = 4'h9;
	localparam logic [2:0]  OC_HIGH_A     = 3'h1;
	localparam logic [2:0]  OC_HIGH_B     = 3'h2;
	localparam logic [2:0]  OC_LOW        = 3'h5;
	localparam int          CM_GATE_LSB   = 13;
	localparam int          CM_SPECIAL    = 7;
	localparam int          CM_RELOAD     = 6;
	localparam int          CM_REPEAT     = 5;
	localparam logic [2:0]  GC_NONE       = 3'h0;
	localparam logic [2:0]  GC_EDGE_HI    = 3'h6;
	localparam logic [2:0]  GC_EDGE_LO    = 3'h7;

	typedef enum logic [1:0] {GATE_NONE, GATE_LEVEL, GATE_EDGE} gate_kind_t;

	typedef struct packed {
		logic       valid;
		logic       reload_load;
		logic [1:0] tc_count;
		gate_kind_t gate_kind;
	} mode_attr_t;

	// Mode family A..L; tc_count 0 means repeat without disarming
	function automatic mode_attr_t decode_mode(input logic [15:0] cm);
		mode_attr_t m;
		logic [2:0] gc;
		gc = cm[CM_GATE_LSB +: 3];
		m.valid = !cm[CM_SPECIAL];
		m.reload_load = !cm[CM_RELOAD];
		if (cm[CM_REPEAT]) begin
			m.tc_count = 2'd0;
		end else if (cm[CM_RELOAD]) begin
			m.tc_count = 2'd2;
		end else begin
			m.tc_count = 2'd1;
		end
		if (gc == GC_NONE) begin
			m.gate_kind = GATE_NONE;
		end else if (gc == GC_EDGE_HI || gc == GC_EDGE_LO) begin
			m.gate_kind = GATE_EDGE;
		end else begin
			m.gate_kind = GATE_LEVEL;
		end
		return m;
	endfunction

	function automatic logic apply_pol(input logic lvl, input logic [2:0] oc);
		return (oc == OC_LOW) ? !lvl : lvl;
	endfunction

	function automatic logic digit_half(input logic [3:0] dg, input logic bcd);
		return bcd ? (dg >= 4'h5) : dg[3];
	endfunction

endpackage

// *** test/host_bus_model.sv ***
// Host model: strobes the control and data ports of the block.
// Assumes the block samples its pins through two sync flops.
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
	input  wire logic        core_clk_i,
	input  wire logic [15:0] db_o_i,
	input  wire logic        db_oe_i,
	input  wire logic [4:0]  aux_gate_i,
	output logic             chip_sel_n_o,
	output logic             rd_n_o,
	output logic             wr_n_o,
	output logic             ctl_sel_o,
	output logic      [15:0] bus_o,
	output logic             hung_o
);
	logic [15:0] rd_val, dq;
	logic [7:0]  last_lo;
	logic        drv;
	event        rd_ev;
	// Released low lines show the inverse of the last byte, never a held value
	assign bus_o = drv ? dq : {3'h7, aux_gate_i, ~last_lo};
	initial begin
		{chip_sel_n_o, rd_n_o, wr_n_o, hung_o, drv} = 5'b11100;
		{ctl_sel_o, dq, last_lo} = '0;
	end
	task automatic wr(input logic ctl, input logic [15:0] d, input int slow);
		@(negedge core_clk_i);
		{chip_sel_n_o, wr_n_o, drv, ctl_sel_o, dq} = {3'b001, ctl, d};
		repeat (4 + slow) @(negedge core_clk_i);
		wr_n_o = 1'b1;
		repeat (4) @(negedge core_clk_i);
		{chip_sel_n_o, drv, last_lo} = {2'b10, d[7:0]};
		repeat (4) @(negedge core_clk_i);
	endtask
	task automatic rd(input logic ctl);
		int n;
		n = 0;
		@(negedge core_clk_i);
		{chip_sel_n_o, rd_n_o, ctl_sel_o} = {2'b00, ctl};
		while (db_oe_i !== 1'b1 && n < 20) begin
			@(negedge core_clk_i);
			n++;
		end
		hung_o = (n == 20);
		// Data stands with the enable, so take it where enable is seen
		rd_val = db_o_i;
		-> rd_ev;
		@(negedge core_clk_i);
		// Read strobe rises first so the block sees the end of the read
		rd_n_o = 1'b1;
		repeat (4) @(negedge core_clk_i);
		chip_sel_n_o = 1'b1;
		repeat (4) @(negedge core_clk_i);
	endtask
endmodule
`default_nettype wire

// *** test/timer_master_mode_control_test.sv ***
// Self-checking bench of the global mode control block.
// Assumes host_bus_model drives the host pins.
`timescale 1ns/1ps
`default_nettype none
module timer_master_mode_control_test import timer_mm_pkg::*;;
	logic        clk, rst, cs_n, rd_n, wr_n, ctl, db_oe, hung, tc1, tc2;
	logic        counter1_output, counter2_output, freq_output, time_of_day, ptr, wide, seq, bcd, mv, mrl, wn;
	logic [15:0] db_i, db_o, c1, c2, a1, a2, cm, w, m;
	logic [4:0]  gate, aux, eff, ifq;
	logic [3:0]  shi;
	logic [2:0]  oc1, oc2;
	logic [1:0]  mtc, mgk;
	logic [1:0]  ph = 2'd0;
	logic [7:0]  cmds [6];
	logic [15:0] exp_q [$];
	int          err_total, n_tests, k, seed;
	timer_master_mode_control u_dut (
		.core_clk_i(clk), .sys_rst_i(rst), .chip_sel_n_i(cs_n),
		.rd_n_i(rd_n), .wr_n_i(wr_n), .ctl_sel_i(ctl), .db_i(db_i),
		.db_o(db_o), .db_oe_o(db_oe), .source_pin_i({shi, ph[1]}),
		.gate_pin_i(gate), .counter1_value_i(c1), .counter2_value_i(c2),
		.alarm1_i(a1), .alarm2_i(a2), .out_ctl1_i(oc1), .out_ctl2_i(oc2),
		.counter1_tc_out_i(tc1), .counter2_tc_out_i(tc2),
		.counter_mode_i(cm), .counter1_output_o(counter1_output),
		.counter2_output_o(counter2_output), .freq_output_o(freq_output),
		.time_of_day_o(time_of_day), .gate_eff_o(eff), .byte_ptr_o(ptr),
		.wide_bus_select_o(wide), .pointer_autoseq_disable_o(seq),
		.scaler_bcd_select_o(bcd), .internal_freq_o(ifq),
		.mode_valid_o(mv), .mode_reload_load_o(mrl),
		.mode_tc_count_o(mtc), .mode_gate_kind_o(mgk));
	host_bus_model u_host (
		.core_clk_i(clk), .db_o_i(db_o), .db_oe_i(db_oe),
		.aux_gate_i(aux), .chip_sel_n_o(cs_n), .rd_n_o(rd_n),
		.wr_n_o(wr_n), .ctl_sel_o(ctl), .bus_o(db_i), .hung_o(hung));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	always @(negedge clk) ph <= ph + 2'd1;
	always @(posedge hung) begin
		err_total++;
		test_done();
	end
	initial forever begin
		@(u_host.rd_ev);
		chk("read", exp_q.pop_front(), u_host.rd_val);
	end
	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			err_total++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic rate(input string nm, input logic sel, input int cyc,
		input int ek);
		int n;
		logic p, v;
		n = 0;
		p = 1'b1;
		repeat (cyc) begin
			@(negedge clk);
			v = sel ? ifq[1] : freq_output;
			if (v && !p) n++;
			p = v;
		end
		chk(nm, 16'((n >= ek - 1 && n <= ek + 1) ? n : ek), 16'(n));
	endtask
	task automatic put(input logic [15:0] d);
		if (wn) u_host.wr(1'b0, d, $urandom % 3);
		else begin
			u_host.wr(1'b0, {3'h7, aux, d[7:0]}, $urandom % 3);
			u_host.wr(1'b0, {3'h7, aux, d[15:8]}, 0);
		end
		{wn, m} = {d[13], d};
	endtask
	task automatic getw();
		if (wn) exp_q.push_back(m);
		else exp_q.push_back({8'h00, m[7:0]});
		u_host.rd(1'b0);
		if (!wn) exp_q.push_back({8'h00, m[15:8]});
		if (!wn) u_host.rd(1'b0);
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		seed = $urandom(32'h4f0d);
		{rst, wn, gate, aux, shi, oc1, oc2, tc1, tc2} = 24'h800000;
		{c1, c2, a1, a2, cm, m, err_total, n_tests} = '0;
		cmds = '{CMD_FGATE_SET, CMD_WIDE_SET, CMD_SEQ_SET, CMD_FGATE_CLR,
			CMD_SEQ_CLR, CMD_WIDE_CLR};
		repeat (3) @(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		chk("reset", 16'h1, {time_of_day, wide, seq, bcd, counter1_output, counter2_output, ptr});
		rate("freq_output f1", 0, 320, 10);
		exp_q.push_back(16'h0001);
		u_host.rd(1'b1);
		w = 16'($urandom) & 16'hdfff;
		put(w);
		chk("flags", {w[15:13], |w[1:0]}, {bcd, seq, wide, time_of_day});
		getw();
		for (int i = 0; i < 6; i++) begin
			u_host.wr(1'b1, {3'h7, aux, cmds[i]}, 0);
			m[12 + (cmds[i] - 8'h1) / 2] = cmds[i][0];
			wn = m[13];
			chk("cmd", {m[14:13], 1'b1}, {seq, wide, ptr});
			getw();
		end
		$display("test host done");
		put(16'h11b0);
		rate("freq_output off", 0, 160, 0);
		u_host.wr(1'b1, {3'h7, aux, CMD_FGATE_CLR}, 0);
		rate("freq_output div1", 0, 160, 80);
		for (int i = 0; i < 3; i++) begin
			k = (i == 0) ? 1 : (i == 1) ? 3 : 16;
			put({4'h0, 4'(k), 8'h10});
			rate("freq_output div", 0, 160 * k, 40);
		end
		for (int b = 0; b < 2; b++) begin
			put({b[0], 15'h0});
			rate("scaler", 1, 640, b ? 32 : 20);
		end
		{gate, aux} = 10'($urandom);
		repeat (6) @(negedge clk);
		chk("aux gate", gate & aux, eff);
		put(16'h2000);
		chk("wide gate", gate, eff);
		$display("test freq done");
		put(16'h000c);
		for (int i = 0; i < 8; i++) begin
			{a1, a2, tc1, tc2} = {16'($urandom), 16'($urandom), 2'($urandom)};
			c1 = i[0] ? a1 : a1 + 16'h1;
			c2 = i[1] ? a2 : ~a2;
			oc1 = i[2] ? OC_LOW : OC_HIGH_A;
			oc2 = i[2] ? OC_LOW : OC_HIGH_B;
			repeat (3) @(negedge clk);
			chk("counter1_output", i[0] ^ i[2], counter1_output);
			chk("counter2_output", (i[0] & i[1]) ^ i[2], counter2_output);
		end
		put(16'h0000);
		chk("normal out", {tc1, tc2}, {counter1_output, counter2_output});
		for (int i = 0; i < 13; i++) begin
			k = (i % 3 == 0) ? 0 : (i % 3 == 1) ? 1 : 6;
			cm = {3'(k), 5'h0, i == 12, i >= 6, (i / 3) % 2 == 1, 5'h0};
			repeat (2) @(negedge clk);
			chk("mode", {i < 12, i < 6, (i / 3) % 2 == 1 ? 2'd0 : i >= 6 ?
				2'd2 : 2'd1, k == 0 ? 2'd0 : k == 6 ? 2'd2 : 2'd1},
				{mv, mrl, mtc, mgk});
		end
		put(16'($urandom));
		u_host.wr(1'b1, {3'h7, aux, CMD_MASTER_RESET}, 0);
		{wn, m} = '0;
		chk("master reset", 16'h1, {time_of_day, wide, seq, bcd, ptr});
		getw();
		$display("test compare done");
		test_done();
	end
endmodule
`default_nettype wire
